// [include/sioc_pkg.sv]
// Package of constants and types for the scan instruction and output control block.
package sioc_pkg;

    localparam int IR_W = 3;
    localparam int DQ_W = 18;
    localparam int ID_W = 32;

    // Instruction encodings; bit 0 is the low instruction bit.
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPZ  = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;

    // Boundary chain layout: control cell at 48, echo pair below it, data above.
    localparam int BSR_W      = 49 + DQ_W;
    localparam int BSR_CTL    = 48;
    localparam int BSR_ECHO_T = 0;
    localparam int BSR_ECHO_C = 1;
    localparam int BSR_DQ     = 49;

    // Identification value; the value is arbitrary.
    localparam logic [31:0] ID_VALUE = 32'h0000_0001;

    // Capture-instruction shift pattern for the instruction register.
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    typedef enum logic [3:0] {
        ST_RESET  = 4'b0000, ST_IDLE   = 4'b0001, ST_SEL_DR = 4'b0010, ST_CAP_DR = 4'b0011,
        ST_SH_DR  = 4'b0100, ST_EX1_DR = 4'b0101, ST_PA_DR  = 4'b0110, ST_EX2_DR = 4'b0111,
        ST_UP_DR  = 4'b1000, ST_SEL_IR = 4'b1001, ST_CAP_IR = 4'b1010, ST_SH_IR  = 4'b1011,
        ST_EX1_IR = 4'b1100, ST_PA_IR  = 4'b1101, ST_EX2_IR = 4'b1110, ST_UP_IR  = 4'b1111
    } sioc_state_t;

    // Output pad group: echo pair and read data.
    typedef struct packed {
        logic            echo_clock_true;
        logic            echo_clock_comp;
        logic [DQ_W-1:0] rdata;
    } sioc_pads_t;

endpackage

// [rtl/sioc_tap_fsm.sv]
// Tap controller state sequencer.
module sioc_tap_fsm (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               tck_rise,
    input  wire logic               tms,
    output sioc_pkg::sioc_state_t   state
);
    sioc_pkg::sioc_state_t state_ff;
    sioc_pkg::sioc_state_t nxt_state;

    assign state = state_ff;

    // Sixteen-state walk, advanced only on a sampled rising test clock edge.
    always_comb begin
        nxt_state = state_ff;
        if (tck_rise) begin
            case (state_ff)
                sioc_pkg::ST_RESET:  nxt_state = tms ? sioc_pkg::ST_RESET  : sioc_pkg::ST_IDLE;
                sioc_pkg::ST_IDLE:   nxt_state = tms ? sioc_pkg::ST_SEL_DR : sioc_pkg::ST_IDLE;
                sioc_pkg::ST_SEL_DR: nxt_state = tms ? sioc_pkg::ST_SEL_IR : sioc_pkg::ST_CAP_DR;
                sioc_pkg::ST_CAP_DR: nxt_state = tms ? sioc_pkg::ST_EX1_DR : sioc_pkg::ST_SH_DR;
                sioc_pkg::ST_SH_DR:  nxt_state = tms ? sioc_pkg::ST_EX1_DR : sioc_pkg::ST_SH_DR;
                sioc_pkg::ST_EX1_DR: nxt_state = tms ? sioc_pkg::ST_UP_DR  : sioc_pkg::ST_PA_DR;
                sioc_pkg::ST_PA_DR:  nxt_state = tms ? sioc_pkg::ST_EX2_DR : sioc_pkg::ST_PA_DR;
                sioc_pkg::ST_EX2_DR: nxt_state = tms ? sioc_pkg::ST_UP_DR  : sioc_pkg::ST_SH_DR;
                sioc_pkg::ST_UP_DR:  nxt_state = tms ? sioc_pkg::ST_SEL_DR : sioc_pkg::ST_IDLE;
                sioc_pkg::ST_SEL_IR: nxt_state = tms ? sioc_pkg::ST_RESET  : sioc_pkg::ST_CAP_IR;
                sioc_pkg::ST_CAP_IR: nxt_state = tms ? sioc_pkg::ST_EX1_IR : sioc_pkg::ST_SH_IR;
                sioc_pkg::ST_SH_IR:  nxt_state = tms ? sioc_pkg::ST_EX1_IR : sioc_pkg::ST_SH_IR;
                sioc_pkg::ST_EX1_IR: nxt_state = tms ? sioc_pkg::ST_UP_IR  : sioc_pkg::ST_PA_IR;
                sioc_pkg::ST_PA_IR:  nxt_state = tms ? sioc_pkg::ST_EX2_IR : sioc_pkg::ST_PA_IR;
                sioc_pkg::ST_EX2_IR: nxt_state = tms ? sioc_pkg::ST_UP_IR  : sioc_pkg::ST_SH_IR;
                sioc_pkg::ST_UP_IR:  nxt_state = tms ? sioc_pkg::ST_SEL_DR : sioc_pkg::ST_IDLE;
                default:             nxt_state = sioc_pkg::ST_RESET;
            endcase
        end
    end

    // State register; reset lands in the test-logic-reset state.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= sioc_pkg::ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

// [rtl/sioc_top.sv]
// Scan instruction decode, boundary chain and output pad control.
// Behaviour
// - Decode three-bit instruction to five instructions.
// - Tristate-sample floats data pads, captures pad levels.
// - Pad source from instruction and control cell.
// - EXTEST: echo drives update; data gated by cell.
// - IDCODE, SAMPLE, BYPASS: pads carry memory output.
// - Tristate-sample also floats echo clock pads.
// - Control cell updates in Update-DR, EXTEST/SAMPLE only.
// - EXTEST, tristate-sample capture actual pad levels.
// - SAMPLE: echo internal; data internal if reading.
// - Capture contents undefined under IDCODE and BYPASS.
// - Idle low test clock leaves memory undisturbed.
// - IDCODE after reset and Test-Logic-Reset entry.
// - BYPASS puts one-stage register between TDI, TDO.
module sioc_top (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 tck,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    output logic                      tdo,
    output logic                      tdo_oe,
    input  wire sioc_pkg::sioc_pads_t sram_out,
    input  wire logic                 sram_reading,
    input  wire sioc_pkg::sioc_pads_t pad_in,
    output sioc_pkg::sioc_pads_t      pad_out,
    output logic                      echo_oe,
    output logic                      rdata_oe
);
    // Pin synchronisers: first stage read only by the second.
    logic [2:0] meta_ff;
    logic [2:0] sync_ff;
    logic       tck_old_ff;
    sioc_pkg::sioc_pads_t pad_meta_ff;
    sioc_pkg::sioc_pads_t pad_sync_ff;

    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_rise;
    logic tck_fall;
    assign tck_s    = sync_ff[2];
    assign tms_s    = sync_ff[1];
    assign tdi_s    = sync_ff[0];
    assign tck_rise = tck_s & ~tck_old_ff;
    assign tck_fall = ~tck_s & tck_old_ff;

    // A test clock tied low never makes an edge, so the TAP and scan registers below hold.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff     <= 3'h0;
            sync_ff     <= 3'h0;
            tck_old_ff  <= 1'b0;
            pad_meta_ff <= '0;
            pad_sync_ff <= '0;
        end else begin
            meta_ff     <= {tck, tms, tdi};
            sync_ff     <= meta_ff;
            tck_old_ff  <= sync_ff[2];
            pad_meta_ff <= pad_in;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    sioc_pkg::sioc_state_t state;

    sioc_tap_fsm u_fsm (
        .clk      (clk),
        .rst      (rst),
        .tck_rise (tck_rise),
        .tms      (tms_s),
        .state    (state)
    );

    // Scan state.
    logic [2:0]                  ir_ff,      nxt_ir;
    logic [2:0]                  irsh_ff,    nxt_irsh;
    logic [31:0]                 idsh_ff,    nxt_idsh;
    logic                        byp_ff,     nxt_byp;
    logic [sioc_pkg::BSR_W-1:0]  bsr_ff,     nxt_bsr;
    logic [sioc_pkg::BSR_W-1:0]  upd_ff,     nxt_upd;
    logic                        tdo_ff,     nxt_tdo;
    logic                        tdo_oe_ff,  nxt_tdo_oe;

    // Capture vector for the boundary chain.
    function automatic logic [sioc_pkg::BSR_W-1:0] capture_vec(
        input logic [2:0]           ins,
        input sioc_pkg::sioc_pads_t pad,
        input sioc_pkg::sioc_pads_t core,
        input logic                 reading,
        input logic                 ctl
    );
        logic [sioc_pkg::BSR_W-1:0] v;
        v = '0;
        v[sioc_pkg::BSR_CTL] = ctl;
        if (ins == sioc_pkg::INS_SAMPLE) begin
            v[sioc_pkg::BSR_ECHO_T] = core.echo_clock_true;
            v[sioc_pkg::BSR_ECHO_C] = core.echo_clock_comp;
            v[sioc_pkg::BSR_DQ +: sioc_pkg::DQ_W] = reading ? core.rdata : pad.rdata;
        end else begin
            // Pad levels; used for EXTEST and the tristate-sample instruction.
            v[sioc_pkg::BSR_ECHO_T] = pad.echo_clock_true;
            v[sioc_pkg::BSR_ECHO_C] = pad.echo_clock_comp;
            v[sioc_pkg::BSR_DQ +: sioc_pkg::DQ_W] = pad.rdata;
        end
        return v;
    endfunction

    logic sel_bsr;
    logic sel_byp;
    assign sel_byp = (ir_ff == sioc_pkg::INS_BYPASS) || (ir_ff[1:0] == 2'b11) || (ir_ff == 3'h5) || (ir_ff == 3'h6);
    assign sel_bsr = (ir_ff == sioc_pkg::INS_EXTEST) || (ir_ff == sioc_pkg::INS_SAMPZ) ||
                     (ir_ff == sioc_pkg::INS_SAMPLE);

    // Next values of the scan registers, moved by test clock edges.
    always_comb begin
        nxt_ir     = ir_ff;
        nxt_irsh   = irsh_ff;
        nxt_idsh   = idsh_ff;
        nxt_byp    = byp_ff;
        nxt_bsr    = bsr_ff;
        nxt_upd    = upd_ff;
        nxt_tdo    = tdo_ff;
        nxt_tdo_oe = tdo_oe_ff;
        if (tck_rise) begin
            case (state)
                sioc_pkg::ST_RESET: begin
                    nxt_ir = sioc_pkg::INS_IDCODE;
                end
                sioc_pkg::ST_CAP_IR: nxt_irsh = sioc_pkg::IR_CAPTURE;
                sioc_pkg::ST_SH_IR:  nxt_irsh = {tdi_s, irsh_ff[2:1]};
                sioc_pkg::ST_UP_IR:  nxt_ir = irsh_ff;
                sioc_pkg::ST_CAP_DR: begin
                    nxt_idsh = sioc_pkg::ID_VALUE;
                    nxt_byp  = 1'b0;
                    if (sel_bsr) begin
                        nxt_bsr = capture_vec(ir_ff, pad_sync_ff, sram_out, sram_reading,
                                              upd_ff[sioc_pkg::BSR_CTL]);
                    end
                end
                sioc_pkg::ST_SH_DR: begin
                    nxt_idsh = {tdi_s, idsh_ff[31:1]};
                    if (sel_byp) begin
                        nxt_byp = tdi_s;
                    end
                    if (sel_bsr) begin
                        nxt_bsr = {tdi_s, bsr_ff[sioc_pkg::BSR_W-1:1]};
                    end
                end
                sioc_pkg::ST_UP_DR: begin
                    // Only these two instructions may move the control cell.
                    if (ir_ff == sioc_pkg::INS_EXTEST || ir_ff == sioc_pkg::INS_SAMPLE) begin
                        nxt_upd = bsr_ff;
                    end
                end
                default: ;
            endcase
        end
        // Serial out is changed on the falling edge so the tester samples it stably.
        if (tck_fall) begin
            nxt_tdo_oe = (state == sioc_pkg::ST_SH_DR) || (state == sioc_pkg::ST_SH_IR);
            // Outside the shift states the pin holds, so a parked port never toggles it.
            if (state == sioc_pkg::ST_SH_IR) begin
                nxt_tdo = irsh_ff[0];
            end else if (state != sioc_pkg::ST_SH_DR) begin
                nxt_tdo = tdo_ff;
            end else if (ir_ff == sioc_pkg::INS_IDCODE) begin
                nxt_tdo = idsh_ff[0];
            end else if (sel_bsr) begin
                nxt_tdo = bsr_ff[0];
            end else begin
                nxt_tdo = byp_ff;
            end
        end
    end

    // Scan registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            ir_ff     <= sioc_pkg::INS_IDCODE;
            irsh_ff   <= 3'h0;
            idsh_ff   <= 32'h0000_0000;
            byp_ff    <= 1'b0;
            bsr_ff    <= '0;
            upd_ff    <= '0;
            tdo_ff    <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else begin
            ir_ff     <= nxt_ir;
            irsh_ff   <= nxt_irsh;
            idsh_ff   <= nxt_idsh;
            byp_ff    <= nxt_byp;
            bsr_ff    <= nxt_bsr;
            upd_ff    <= nxt_upd;
            tdo_ff    <= nxt_tdo;
            tdo_oe_ff <= nxt_tdo_oe;
        end
    end

    assign tdo    = tdo_ff;
    assign tdo_oe = tdo_oe_ff;

    // Pad drive; registered so the outputs come from flip-flops.
    sioc_pkg::sioc_pads_t pad_ff, nxt_pad;
    logic                 echo_oe_ff, nxt_echo_oe;
    logic                 rdata_oe_ff, nxt_rdata_oe;

    always_comb begin
        nxt_pad      = sram_out;
        nxt_echo_oe  = 1'b1;
        nxt_rdata_oe = 1'b1;
        if (ir_ff == sioc_pkg::INS_EXTEST) begin
            nxt_pad.echo_clock_true = upd_ff[sioc_pkg::BSR_ECHO_T];
            nxt_pad.echo_clock_comp = upd_ff[sioc_pkg::BSR_ECHO_C];
            nxt_pad.rdata           = upd_ff[sioc_pkg::BSR_DQ +: sioc_pkg::DQ_W];
            nxt_rdata_oe            = upd_ff[sioc_pkg::BSR_CTL];
        end else if (ir_ff == sioc_pkg::INS_SAMPZ) begin
            nxt_echo_oe  = 1'b0;
            nxt_rdata_oe = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pad_ff      <= '0;
            echo_oe_ff  <= 1'b1;
            rdata_oe_ff <= 1'b1;
        end else begin
            pad_ff      <= nxt_pad;
            echo_oe_ff  <= nxt_echo_oe;
            rdata_oe_ff <= nxt_rdata_oe;
        end
    end

    assign pad_out  = pad_ff;
    assign echo_oe  = echo_oe_ff;
    assign rdata_oe = rdata_oe_ff;
endmodule

// [verif/sioc_monitor.sv]
// Checker of pad enables and serial port timing, bound to the top module.
module sioc_monitor (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 tck,
    input wire logic                 tdo,
    input wire logic                 tdo_oe,
    input wire sioc_pkg::sioc_pads_t pad_out,
    input wire logic                 echo_oe,
    input wire logic                 rdata_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] tck_h;
    logic [3:0] low_cnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Test clock history and a saturating count of low cycles; a resting port is judged by it.
    always_ff @(posedge clk) begin
        if (rst) begin
            tck_h   <= 8'h00;
            low_cnt <= 4'h0;
        end else begin
            tck_h   <= {tck_h[6:0], tck};
            low_cnt <= tck ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hf};
        end
    end

    property p_reset_oe; $fell(rst) |-> echo_oe && rdata_oe && !tdo_oe; endproperty
    a_reset_oe: assert property (p_reset_oe) else $error("enables wrong after reset");
    property p_z_pair; !echo_oe |-> !rdata_oe; endproperty
    a_z_pair: assert property (p_z_pair) else $error("data pads drive while echo pads float");
    property p_idle; low_cnt >= 4'h8 |-> $stable(tdo) && $stable(tdo_oe) && $stable({echo_oe, rdata_oe}); endproperty
    a_idle: assert property (p_idle) else $error("port moved with test clock at rest");
    property p_oe_edge; $changed({echo_oe, rdata_oe}) |-> |tck_h; endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("pad enable changed without test clock");
    property p_tdo_oe_edge; $changed(tdo_oe) |-> |tck_h; endproperty
    a_tdo_oe_edge: assert property (p_tdo_oe_edge) else $error("serial enable moved without test clock");
    property p_tdo_shift; $changed(tdo) |-> tdo_oe || $past(tdo_oe); endproperty
    a_tdo_shift: assert property (p_tdo_shift) else $error("serial out moved outside shifting");
    property p_extest_hold;
        echo_oe && !rdata_oe && low_cnt >= 4'h8 |->
            $stable(pad_out.echo_clock_true) && $stable(pad_out.echo_clock_comp);
    endproperty
    a_extest_hold: assert property (p_extest_hold) else $error("echo pads left the update value");
    property p_ctl_quiet; $changed(rdata_oe) && $stable(echo_oe) |-> !tdo_oe; endproperty
    a_ctl_quiet: assert property (p_ctl_quiet) else $error("data enable moved while shifting");
endmodule

bind sioc_top sioc_monitor u_mon (.clk(clk), .rst(rst), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
    .pad_out(pad_out), .echo_oe(echo_oe), .rdata_oe(rdata_oe));

// [verif/sioc_tester.sv]
// Model of the board tester that walks the serial test port.
module sioc_tester (
    input  wire logic clk,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    timeunit 1ns;
    timeprecision 1ps;

    // The test clock rests low between frames, as on an unused port.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One test clock period; tdo is read just before the rise, tdi is inverted once released.
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge clk);
        @(negedge clk) q = tdo;
        @(posedge clk) tck <= 1'b1;
        repeat (5) @(posedge clk);
        tck <= 1'b0;
        tdi <= ~d;
    endtask

    // Five high steps reach Test-Logic-Reset from any state; one low step parks in Idle.
    task automatic tap_reset();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask

    // Scans n bits bit 0 first through the instruction or data path, then back to Idle.
    task automatic scan(input logic ir, input int n, input logic [66:0] din, output logic [66:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule

// [verif/test_sioc_top.sv]
// Self-checking bench for the scan instruction and output control block.
module test_sioc_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [2:0] ins; logic ctl; logic eoe; logic roe;} sioc_row_t;
    logic                 clk, rst, tck, tms, tdi, tdo, tdo_oe, sram_reading, echo_oe, rdata_oe;
    sioc_pkg::sioc_pads_t sram_out, pad_in, pad_out, core, pins, want;
    sioc_pkg::sioc_pads_t upd = '{1'b1, 1'b0, 18'h2_d2b4};
    logic [66:0]          dout;
    sioc_row_t            rows [7];
    int                   bad_count = 0;
    int                   checks_done = 0;

    sioc_top uut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .sram_out(sram_out), .sram_reading(sram_reading), .pad_in(pad_in), .pad_out(pad_out),
        .echo_oe(echo_oe), .rdata_oe(rdata_oe));
    sioc_tester tst (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

    // System clock of 8 ns.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check_vec(input string what, input logic [66:0] exp, input logic [66:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Boundary chain image: echo pair at 0 and 1, control cell at 48, data from 49 up.
    function automatic logic [66:0] chain(input sioc_pkg::sioc_pads_t p, input logic c);
        chain = '0;
        {chain[0], chain[1], chain[48], chain[66:49]} = {p.echo_clock_true, p.echo_clock_comp, c, p.rdata};
    endfunction

    task automatic load_ir(input logic [2:0] code);
        logic [66:0] d;
        tst.scan(1'b1, 3, 67'(code), d);
        check_vec("ir capture", 67'(sioc_pkg::IR_CAPTURE), 67'(d[2:0]));
    endtask

    task automatic expect_id();
        tst.scan(1'b0, 32, '0, dout);
        check_vec("idcode", 67'(sioc_pkg::ID_VALUE), 67'(dout[31:0]));
    endtask

    // A hang counts as a mismatch; the span covers the whole sequence with margin.
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        stop_test();
    end

    initial begin
        {sram_out, pad_in, sram_reading} = '0;
        rst = 1'b1;
        rows[0] = '{sioc_pkg::INS_EXTEST, 1'b0, 1'b1, 1'b0};
        rows[1] = '{sioc_pkg::INS_EXTEST, 1'b1, 1'b1, 1'b1};
        rows[2] = '{sioc_pkg::INS_IDCODE, 1'b1, 1'b1, 1'b1};
        rows[3] = '{sioc_pkg::INS_SAMPZ, 1'b0, 1'b0, 1'b0};
        rows[4] = '{sioc_pkg::INS_SAMPLE, 1'b0, 1'b1, 1'b1};
        rows[5] = '{sioc_pkg::INS_SAMPLE, 1'b1, 1'b1, 1'b1};
        rows[6] = '{sioc_pkg::INS_BYPASS, 1'b0, 1'b1, 1'b1};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check_vec("enables after reset", 67'h6, 67'({echo_oe, rdata_oe, tdo_oe}));
        tst.tap_reset();
        expect_id();
        $display("test reset done");
        // Each row: set the control cell under SAMPLE, load the instruction, check pads and capture.
        foreach (rows[k]) begin
            core = '{1'b0, 1'b1, 18'h0_5a5a ^ 18'(k)};
            pins = '{1'b1, 1'b1, 18'h3_0f0f};
            load_ir(sioc_pkg::INS_SAMPLE);
            tst.scan(1'b0, 67, chain(upd, rows[k].ctl), dout);
            load_ir(rows[k].ins);
            repeat (10) @(posedge clk);
            {sram_out, pad_in, sram_reading} <= {core, pins, rows[k].ctl};
            repeat (4) @(posedge clk);
            @(negedge clk);
            check_vec("echo_oe", 67'(rows[k].eoe), 67'(echo_oe));
            check_vec("rdata_oe", 67'(rows[k].roe), 67'(rdata_oe));
            want = rows[k].ins == sioc_pkg::INS_EXTEST ? upd : core;
            if (rows[k].eoe) check_vec("echo pads", 67'(want[19:18]), 67'(pad_out[19:18]));
            if (rows[k].roe) check_vec("pad_out", 67'(want), 67'(pad_out));
            tst.scan(1'b0, 67, chain(upd, rows[k].ctl), dout);
            want = rows[k].ins == sioc_pkg::INS_SAMPLE ?
                '{core.echo_clock_true, core.echo_clock_comp, rows[k].ctl ? core.rdata : pins.rdata} : pins;
            if (rows[k].ins == sioc_pkg::INS_IDCODE) begin
                check_vec("idcode row", 67'(sioc_pkg::ID_VALUE), 67'(dout[31:0]));
            end else if (rows[k].ins == sioc_pkg::INS_BYPASS) begin
                check_vec("bypass", chain(upd, rows[k].ctl) << 1, dout);
            end else begin
                // The control cell is captured too, so its value from the preload is seen here.
                check_vec("capture", 67'({want, rows[k].ctl}),
                          67'({dout[0], dout[1], dout[66:49], dout[48]}));
            end
        end
        $display("test rows done");
        // The control cell must ignore Update-DR under the tristate-sample instruction.
        load_ir(sioc_pkg::INS_SAMPLE);
        tst.scan(1'b0, 67, chain(upd, 1'b0), dout);
        load_ir(sioc_pkg::INS_SAMPZ);
        tst.scan(1'b0, 67, chain(upd, 1'b1), dout);
        load_ir(sioc_pkg::INS_EXTEST);
        @(negedge clk);
        check_vec("rdata_oe kept", 67'h0, 67'(rdata_oe));
        $display("test control cell done");
        // Test-Logic-Reset entry brings back the identification path; after a second system reset only the enables are checked before the next tap reset.
        tst.tap_reset();
        expect_id();
        load_ir(sioc_pkg::INS_EXTEST);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check_vec("enables after second reset", 67'h6, 67'({echo_oe, rdata_oe, tdo_oe}));
        tst.tap_reset();
        expect_id();
        $display("test tap reset done");
        stop_test();
    end
endmodule
